// ==== synth_prog_pkg.sv ====
// ****************************************************************
// program word layout and register constants
// ****************************************************************
package synth_prog_pkg;

  // serial word framing
  localparam int unsigned WORD_BITS = 32;
  localparam logic [5:0] WORD_BITS_CNT = 6'h20;
  localparam logic [5:0] CNT_SATURATE = 6'h21;
  localparam int unsigned SEL_MSB = 3;
  localparam int unsigned SEL_LSB = 0;

  // register select codes
  localparam logic [3:0] SEL_INTEGER = 4'h0;
  localparam logic [3:0] SEL_FRACTION = 4'h1;
  localparam logic [3:0] SEL_CONVERTER = 4'ha;
  localparam logic [3:0] SEL_FIXED_B = 4'hb;

  // integer, prescaler and calibration register fields
  localparam int unsigned INT_MSB = 19;
  localparam int unsigned INT_LSB = 4;
  localparam int unsigned PRESCALER_BIT = 20;
  localparam int unsigned CAL_ENABLE_BIT = 21;
  localparam int unsigned INT_RSVD_MSB = 31;
  localparam int unsigned INT_RSVD_LSB = 22;

  // main fraction register field
  localparam int unsigned FRAC_MSB = 27;
  localparam int unsigned FRAC_LSB = 4;

  // converter control register fields
  localparam int unsigned ADC_DIV_MSB = 13;
  localparam int unsigned ADC_DIV_LSB = 6;
  localparam int unsigned CONV_ENABLE_BIT = 5;
  localparam int unsigned ADC_ENABLE_BIT = 4;

  // fixed reserved pattern expected at select code eleven
  localparam logic [31:0] FIXED_B_PATTERN = 32'h0081200b;

  // integer limits per prescaler (select bit 0 is 4/5, 1 is 8/9)
  localparam logic [15:0] INT_MIN_P45 = 16'h0017;
  localparam logic [15:0] INT_MAX_P45 = 16'h7fff;
  localparam logic [15:0] INT_MIN_P89 = 16'h004b;

  // reset values, nothing defined so all registers clear but the illegal flag, which resets high
  localparam logic [15:0] INT_RESET = 16'h0000;
  localparam logic [23:0] FRAC_RESET = 24'h000000;
  localparam logic [7:0] ADC_DIV_RESET = 8'h00;

endpackage : synth_prog_pkg

// ==== word_if.sv ====
`timescale 1ns/1ps
// ****************************************************************
// received program word from the serial front end
// ****************************************************************
interface word_if;
  logic [31:0] word;
  logic valid;

  modport rx (output word, output valid);
  modport core (input word, input valid);
endinterface : word_if

// ==== serial_word_rx.sv ====
`timescale 1ns/1ps
// ****************************************************************
// three-wire serial receiver, oversampled on the system clock
// ****************************************************************
module serial_word_rx (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_le_i,
  word_if.rx wif
);

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic clk_prev;
  logic le_prev;
  logic [31:0] shift;
  logic [5:0] cnt;
  logic [31:0] next_shift;
  logic [5:0] next_cnt;
  logic [31:0] next_word;
  logic next_valid;
  logic clk_rise;
  logic le_rise;

  // two-stage synchronisers for clock, data and load enable pins
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end
    else
    begin
      sync_a <= {ser_le_i, ser_data_i, ser_clk_i};
      sync_b <= sync_a;
    end
  end

  assign clk_rise = sync_b[0] && !clk_prev;
  assign le_rise = sync_b[2] && !le_prev;

  // shift msb first while load enable is low; a word is taken on le rising
  always_comb
  begin
    next_shift = shift;
    next_cnt = cnt;
    next_word = wif.word;
    next_valid = 1'b0;
    if (le_rise)
    begin
      // short or long frames are dropped rather than guessed at
      if (cnt == synth_prog_pkg::WORD_BITS_CNT)
      begin
        next_word = shift;
        next_valid = 1'b1;
      end
      next_cnt = 6'h00;
    end
    else if (clk_rise && !sync_b[2])
    begin
      next_shift = {shift[30:0], sync_b[1]};
      if (cnt != synth_prog_pkg::CNT_SATURATE)
        next_cnt = cnt + 6'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clk_prev <= 1'b0;
      le_prev <= 1'b0;
      shift <= 32'h00000000;
      cnt <= 6'h00;
      wif.word <= 32'h00000000;
      wif.valid <= 1'b0;
    end
    else
    begin
      clk_prev <= sync_b[0];
      le_prev <= sync_b[2];
      shift <= next_shift;
      cnt <= next_cnt;
      wif.word <= next_word;
      wif.valid <= next_valid;
    end
  end

  chk_word_length_only: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wif.valid |-> $past(cnt) == synth_prog_pkg::WORD_BITS_CNT)
    else $error("word delivered without exactly 32 bits");

endmodule : serial_word_rx

// ==== synth_program_registers.sv ====
`timescale 1ns/1ps
module synth_program_registers (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_le_i,
  output logic [15:0] int_value_o,
  output logic prescaler_sel_o,
  output logic [23:0] main_fraction_numerator_o,
  output logic cal_start_o,
  output logic update_o,
  output logic [7:0] converter_clock_divider_o,
  output logic conversion_enable_bit_o,
  output logic converter_enable_bit_o,
  output logic int_illegal_o,
  output logic pattern_error_o
);

  word_if wif ();

  // ****************************************************************
  // serial front end
  // ****************************************************************
  serial_word_rx u_rx (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .ser_clk_i(ser_clk_i),
    .ser_data_i(ser_data_i),
    .ser_le_i(ser_le_i),
    .wif(wif)
  );

  // ****************************************************************
  // register decode and update
  // ****************************************************************
  logic [3:0] sel;
  logic wr_int;
  logic wr_frac;
  logic wr_conv;
  logic wr_fix;
  logic [23:0] frac_shadow;
  logic [23:0] next_frac_shadow;
  logic [15:0] next_int;
  logic next_presc;
  logic [23:0] next_frac;
  logic next_cal;
  logic next_update;
  logic [7:0] next_div;
  logic next_conv;
  logic next_adc;
  logic next_illegal;
  logic next_pattern_err;

  // register select is always the low nibble of the delivered word
  assign sel = wif.word[synth_prog_pkg::SEL_MSB:synth_prog_pkg::SEL_LSB];
  assign wr_int = wif.valid && (sel == synth_prog_pkg::SEL_INTEGER);
  assign wr_frac = wif.valid && (sel == synth_prog_pkg::SEL_FRACTION);
  assign wr_conv = wif.valid && (sel == synth_prog_pkg::SEL_CONVERTER);
  assign wr_fix = wif.valid && (sel == synth_prog_pkg::SEL_FIXED_B);

  // next values; codes with no modelled fields are accepted and dropped
  always_comb
  begin
    next_frac_shadow = frac_shadow;
    next_int = int_value_o;
    next_presc = prescaler_sel_o;
    next_frac = main_fraction_numerator_o;
    next_cal = 1'b0;
    next_update = 1'b0;
    next_div = converter_clock_divider_o;
    next_conv = conversion_enable_bit_o;
    next_adc = converter_enable_bit_o;
    next_pattern_err = pattern_error_o;
    if (wr_frac)
    begin
      // fraction waits in the shadow stage until the integer write
      next_frac_shadow = wif.word[synth_prog_pkg::FRAC_MSB:synth_prog_pkg::FRAC_LSB];
    end
    if (wr_int)
    begin
      next_int = wif.word[synth_prog_pkg::INT_MSB:synth_prog_pkg::INT_LSB];
      next_presc = wif.word[synth_prog_pkg::PRESCALER_BIT];
      next_frac = frac_shadow;
      next_update = 1'b1;
      // a clear enable bit leaves the oscillator in its present band
      next_cal = wif.word[synth_prog_pkg::CAL_ENABLE_BIT];
    end
    if (wr_conv)
    begin
      next_div = wif.word[synth_prog_pkg::ADC_DIV_MSB:synth_prog_pkg::ADC_DIV_LSB];
      next_conv = wif.word[synth_prog_pkg::CONV_ENABLE_BIT];
      next_adc = wif.word[synth_prog_pkg::ADC_ENABLE_BIT];
    end
    if (wr_fix)
    begin
      // the device cannot enforce the pattern, it only reports a wrong one
      next_pattern_err = (wif.word != synth_prog_pkg::FIXED_B_PATTERN);
    end
  end

  // limit check against the integer and prescaler about to be active
  always_comb
  begin
    if (next_presc)
      next_illegal = (next_int < synth_prog_pkg::INT_MIN_P89);
    else
      next_illegal = (next_int < synth_prog_pkg::INT_MIN_P45) ||
                     (next_int > synth_prog_pkg::INT_MAX_P45);
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      frac_shadow <= synth_prog_pkg::FRAC_RESET;
      int_value_o <= synth_prog_pkg::INT_RESET;
      prescaler_sel_o <= 1'b0;
      main_fraction_numerator_o <= synth_prog_pkg::FRAC_RESET;
      cal_start_o <= 1'b0;
      update_o <= 1'b0;
      converter_clock_divider_o <= synth_prog_pkg::ADC_DIV_RESET;
      conversion_enable_bit_o <= 1'b0;
      converter_enable_bit_o <= 1'b0;
      int_illegal_o <= 1'b1;
      pattern_error_o <= 1'b0;
    end
    else
    begin
      frac_shadow <= next_frac_shadow;
      int_value_o <= next_int;
      prescaler_sel_o <= next_presc;
      main_fraction_numerator_o <= next_frac;
      cal_start_o <= next_cal;
      update_o <= next_update;
      converter_clock_divider_o <= next_div;
      conversion_enable_bit_o <= next_conv;
      converter_enable_bit_o <= next_adc;
      int_illegal_o <= next_illegal;
      pattern_error_o <= next_pattern_err;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking dflt @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence frac_then_int;
    wr_frac ##[1:400] wr_int;
  endsequence

  sequence int_write_cal;
    wr_int && wif.word[21];
  endsequence

  chk_int_value_load: assert property (wr_int |=> int_value_o == $past(wif.word[19:4]))
    else $error("integer value not loaded from select code zero");

  chk_int_field_bits: assert property (wr_int |=> int_value_o[0] == $past(wif.word[4])
    && int_value_o[15] == $past(wif.word[19]))
    else $error("integer field bit positions wrong");

  chk_cal_start_pulse: assert property (int_write_cal |=> cal_start_o ##1 !cal_start_o)
    else $error("calibration pulse missing or too long");

  chk_cal_default_only: assert property (cal_start_o |-> $past(wr_int))
    else $error("calibration started without integer write");

  chk_cal_skip_off: assert property (wr_int && !wif.word[21] |=> !cal_start_o)
    else $error("calibration ran with enable clear");

  chk_presc_select: assert property (wr_int |=> prescaler_sel_o == $past(wif.word[20]))
    else $error("prescaler select not taken from bit 20");

  chk_frac_held: assert property (wr_frac && !wr_int |=> $stable(main_fraction_numerator_o))
    else $error("fraction changed before integer write");

  chk_frac_transfer: assert property (frac_then_int |=> update_o
    && main_fraction_numerator_o == $past(frac_shadow))
    else $error("buffered fraction not applied on integer write");

  chk_conv_fields: assert property (wr_conv |=> converter_clock_divider_o == $past(wif.word[13:6])
    && conversion_enable_bit_o == $past(wif.word[5]) && converter_enable_bit_o == $past(wif.word[4]))
    else $error("converter control fields misplaced");

  chk_int_min_flag: assert property (wr_int && wif.word[20] && wif.word[19:4] < 16'h004b
    |=> int_illegal_o)
    else $error("integer below 8/9 minimum not flagged");

  // low side of the 4/5 range; the 4/5 maximum has no check of its own
  chk_int_low_p45: assert property (wr_int && !wif.word[20] && wif.word[19:4] < 16'h0017
    |=> int_illegal_o)
    else $error("integer below 4/5 minimum not flagged");

  // a legal 8/9 value must clear the flag, or the flag could be stuck high
  chk_int_legal_p89: assert property (wr_int && wif.word[20] && wif.word[19:4] >= 16'h004b
    |=> !int_illegal_o)
    else $error("legal 8/9 integer flagged");

  // every integer write moves the buffered fields exactly once
  chk_update_pulse: assert property (wr_int |=> update_o ##1 !update_o)
    else $error("update pulse missing or too long");

  // fraction lands in the shadow stage straight away, not in the output
  chk_frac_shadow_load: assert property (wr_frac |=> frac_shadow == $past(wif.word[27:4]))
    else $error("fraction not captured in shadow stage");

  // the pattern flag follows the last word at select code eleven
  chk_pattern_flag: assert property (wr_fix
    |=> pattern_error_o == ($past(wif.word) != synth_prog_pkg::FIXED_B_PATTERN))
    else $error("pattern flag does not match last fixed word");

endmodule : synth_program_registers

// ==== host_serial_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// host controller on the three-wire programming pins
// ****************************************************************
module host_serial_model (
  input wire logic sys_clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_le_o
);
  // idle: serial clock parked low, load enable high between frames
  initial
  begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_le_o = 1'b1;
  end

  // shifts the top nbits of w, msb first; each phase held 4 cycles, three above the one-cycle minimum
  task automatic send_word(input logic [31:0] w, input int nbits);
    begin
      @(posedge sys_clk_i);
      ser_le_o <= 1'b0;
      for (int i = 31; i > 31 - nbits; i--)
      begin
        ser_data_o <= w[i];
        repeat (4) @(posedge sys_clk_i);
        ser_clk_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        ser_clk_o <= 1'b0;
      end
      repeat (4) @(posedge sys_clk_i);
      ser_le_o <= 1'b1;
      // data no longer meaningful, so show the inverse rather than a stale bit
      ser_data_o <= ~ser_data_o;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask : send_word
endmodule : host_serial_model

// ==== synth_program_registers_tb_top.sv ====
`timescale 1ns/1ps
module synth_program_registers_tb_top;
  logic sys_clk_i;
  logic arst_n_i;
  logic ser_clk, ser_data, ser_le;
  logic [15:0] int_value;
  logic prescaler_sel, cal_start, update, conv_en, adc_en, int_illegal, pattern_error;
  logic [23:0] fraction;
  logic [7:0] adc_div;
  logic [23:0] exp_frac;
  int n_fail, checks, n_cal, n_upd;

  host_serial_model u_host (.sys_clk_i(sys_clk_i), .ser_clk_o(ser_clk),
    .ser_data_o(ser_data), .ser_le_o(ser_le));

  synth_program_registers u_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .ser_clk_i(ser_clk), .ser_data_i(ser_data), .ser_le_i(ser_le),
    .int_value_o(int_value), .prescaler_sel_o(prescaler_sel),
    .main_fraction_numerator_o(fraction), .cal_start_o(cal_start), .update_o(update),
    .converter_clock_divider_o(adc_div), .conversion_enable_bit_o(conv_en),
    .converter_enable_bit_o(adc_en), .int_illegal_o(int_illegal),
    .pattern_error_o(pattern_error));

  // ****************************************************************
  // clock, pulse counters and report
  // ****************************************************************
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // counting pulses also catches one that stays high too long
  always @(posedge sys_clk_i)
  begin
    if (cal_start === 1'b1) n_cal++;
    if (update === 1'b1) n_upd++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      checks++;
      if (got !== exp)
      begin
        n_fail++;
        $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask : check

  task automatic end_sim();
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask : end_sim

  // sends a word and lets the four cycle answer settle
  task automatic send(input logic [31:0] w, input int nbits);
    begin
      u_host.send_word(w, nbits);
      repeat (6) @(posedge sys_clk_i);
    end
  endtask : send

  // integer write; reserved bits 31:22 kept zero, legality worked out from the limits
  task automatic write_int(input logic cal, input logic pre, input logic [15:0] n);
    int c0, u0;
    logic ill;
    begin
      c0 = n_cal;
      u0 = n_upd;
      ill = pre ? (n < 16'd75) : (n < 16'd23 || n > 16'd32767);
      send({10'h000, cal, pre, n, 4'h0}, 32);
      check({16'h0000, int_value}, {16'h0000, n}, "integer");
      check({31'h0, prescaler_sel}, {31'h0, pre}, "prescaler");
      check({31'h0, int_illegal}, {31'h0, ill}, "illegal flag");
      check(n_cal - c0, {31'h0, cal}, "calibration pulses");
      check(n_upd - u0, 32'h1, "update pulses");
      check({8'h00, fraction}, {8'h00, exp_frac}, "fraction");
    end
  endtask : write_int

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    end_sim();
  end

  initial
  begin
    arst_n_i = 1'b0;
    n_fail = 0;
    checks = 0;
    n_cal = 0;
    n_upd = 0;
    exp_frac = 24'h000000;
    repeat (6) @(posedge sys_clk_i);
    check({31'h0, int_illegal}, 32'h1, "reset illegal");
    check({8'h00, fraction}, 32'h0, "reset fraction");
    arst_n_i <= 1'b1;
    send({4'h0, 24'habcdef, 4'h1}, 32);
    check({8'h00, fraction}, 32'h0, "fraction before apply");
    exp_frac = 24'habcdef;
    write_int(1'b1, 1'b0, 16'd23);
    write_int(1'b0, 1'b0, 16'd22);
    write_int(1'b1, 1'b0, 16'h8000);
    write_int(1'b0, 1'b1, 16'd74);
    write_int(1'b1, 1'b1, 16'hffff);
    send({18'h00000, 8'ha5, 1'b1, 1'b0, 4'ha}, 32);
    check({24'h0, adc_div, conv_en, adc_en}, {24'h0, 8'ha5, 2'b10}, "converter");
    send({18'h00000, 8'h5a, 1'b0, 1'b1, 4'ha}, 32);
    check({24'h0, adc_div, conv_en, adc_en}, {24'h0, 8'h5a, 2'b01}, "converter");
    send(synth_prog_pkg::FIXED_B_PATTERN, 32);
    check({31'h0, pattern_error}, 32'h0, "pattern ok");
    send(synth_prog_pkg::FIXED_B_PATTERN ^ 32'h00000100, 32);
    check({31'h0, pattern_error}, 32'h1, "pattern bad");
    // a short fraction frame must be dropped, so the old shadow value survives
    send({4'h0, 24'h123456, 4'h1}, 31);
    write_int(1'b1, 1'b0, 16'd75);
    send({4'h0, 24'h000001, 4'h1}, 32);
    exp_frac = 24'h000001;
    write_int(1'b0, 1'b1, 16'd75);
    end_sim();
  end
endmodule : synth_program_registers_tb_top
